// ### shared/cfg_pkg.sv
package cfg_pkg;

   // logical device numbers, held in address bits 13:10
   localparam logic [3:0] LDN_IRQ = 4'h0;
   localparam logic [3:0] LDN_SERIAL = 4'h4;
   localparam logic [3:0] LDN_MIDI = 4'h5;
   localparam logic [3:0] LDN_KBD = 4'h7;

   // configuration indices, held in address bits 9:2
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h00;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h01;
   localparam logic [7:0] IDX_MIDI_HIGH = 8'h60;
   localparam logic [7:0] IDX_MIDI_LOW = 8'h61;
   localparam logic [7:0] IDX_SERIAL_MODE = 8'hf0;
   localparam logic [7:0] IDX_KBD_SELECT = 8'hf0;

   // serial mode control fields
   localparam int SER_MIDI_BIT = 0;
   localparam int SER_SPEED_BIT = 1;
   localparam int SER_SHARE_BIT = 7;
   localparam logic [7:0] SER_WR_MASK = 8'h83;
   localparam logic [7:0] SER_RESET = 8'h00;

   // midi base address fields
   localparam logic [7:0] MIDI_HIGH_WR_MASK = 8'h0f;
   localparam logic [7:0] MIDI_LOW_WR_MASK = 8'hfe;
   localparam logic [7:0] MIDI_HIGH_RESET = 8'h00;
   localparam logic [7:0] MIDI_LOW_RESET = 8'h30;

   // keyboard reset and a20 select fields
   localparam int KBD_POL_BIT = 7;
   localparam int KBD_MISO_BIT = 6;
   localparam int KBD_KISO_BIT = 5;
   localparam int KBD_MIRQ_SEL_BIT = 4;
   localparam int KBD_KIRQ_SEL_BIT = 3;
   localparam int KBD_P92_BIT = 2;
   localparam logic [7:0] KBD_WR_MASK = 8'hfc;
   localparam logic [7:0] KBD_RESET = 8'h00;

   // interrupt status and mask layout
   localparam int IRQ_KBD_BIT = 0;
   localparam int IRQ_MOUSE_BIT = 1;
   localparam int IRQ_SERIAL_BIT = 2;
   localparam int IRQ_WIDTH = 3;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // register selected by an access
   typedef enum {
      REG_NONE,
      REG_IRQ_STATUS,
      REG_IRQ_MASK,
      REG_MIDI_HIGH,
      REG_MIDI_LOW,
      REG_SERIAL,
      REG_KBD
   } reg_e;

endpackage : cfg_pkg

// ### hw/serial_midi_kbd_config.sv
`timescale 1ns/100ps
`default_nettype none

module serial_midi_kbd_config (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // serial and midi units
   input wire logic UART_IRQ,
   input wire logic MIDI_IRQ,
   output logic UART_IRQ_OUT,
   output logic MIDI_IRQ_OUT,
   output logic MIDI_MODE_EN,
   output logic HIGH_SPEED_EN,
   output logic [11:0] MIDI_BASE_ADDR,
   // keyboard controller core
   input wire logic KBD_CORE_IRQ,
   input wire logic MOUSE_CORE_IRQ,
   input wire logic KBD_IRQ_ACK,
   input wire logic MOUSE_IRQ_ACK,
   input wire logic RESET_OUTPUT_LINE,
   input wire logic CORE_ADDR20,
   input wire logic PORT92_ADDR20,
   output logic KEYBOARD_IRQ,
   output logic MOUSE_IRQ,
   output logic KEYBOARD_RESET_OUT,
   output logic ADDR20_GATE,
   output logic PORT92_EN,
   // keyboard and mouse pins
   input wire logic KBD_CLK_PIN,
   input wire logic KEYBOARD_DATA_LINE,
   input wire logic MOUSE_CLK_PIN,
   input wire logic MOUSE_DATA_LINE,
   output logic KBD_CLK_TO_CORE,
   output logic KBD_DATA_TO_CORE,
   output logic MOUSE_CLK_TO_CORE,
   output logic MOUSE_DATA_TO_CORE,
   output logic KBD_DATA_WAKE,
   output logic MOUSE_DATA_WAKE,
   // interrupt
   output logic IRQ_OUT
);

   // address to register decode
   function automatic cfg_pkg::reg_e regsel_f(input logic [31:0] addr);
      logic [3:0] ldn;
      logic [7:0] idx;
      ldn = addr[13:10];
      idx = addr[9:2];
      regsel_f = cfg_pkg::REG_NONE;
      if (addr[31:14] == 18'h0_0000) begin
         case (ldn)
            cfg_pkg::LDN_IRQ: begin
               if (idx == cfg_pkg::IDX_IRQ_STATUS) begin
                  regsel_f = cfg_pkg::REG_IRQ_STATUS;
               end else if (idx == cfg_pkg::IDX_IRQ_MASK) begin
                  regsel_f = cfg_pkg::REG_IRQ_MASK;
               end
            end
            cfg_pkg::LDN_SERIAL: begin
               if (idx == cfg_pkg::IDX_SERIAL_MODE) begin
                  regsel_f = cfg_pkg::REG_SERIAL;
               end
            end
            cfg_pkg::LDN_MIDI: begin
               if (idx == cfg_pkg::IDX_MIDI_HIGH) begin
                  regsel_f = cfg_pkg::REG_MIDI_HIGH;
               end else if (idx == cfg_pkg::IDX_MIDI_LOW) begin
                  regsel_f = cfg_pkg::REG_MIDI_LOW;
               end
            end
            cfg_pkg::LDN_KBD: begin
               // indices f1..ff stay REG_NONE and read zero
               if (idx == cfg_pkg::IDX_KBD_SELECT) begin
                  regsel_f = cfg_pkg::REG_KBD;
               end
            end
            default: begin
               regsel_f = cfg_pkg::REG_NONE;
            end
         endcase
      end
   endfunction : regsel_f

   // bus state
   logic wr_pend_d, wr_pend_q;
   cfg_pkg::reg_e wsel_d, wsel_q;
   logic [31:0] rdata_d, rdata_q;
   logic ready_q;
   // register state
   logic [7:0] ser_d, ser_q;
   logic [7:0] mhi_d, mhi_q;
   logic [7:0] mlo_d, mlo_q;
   logic [7:0] kbd_d, kbd_q;
   logic [2:0] st_d, st_q;
   logic [2:0] mask_d, mask_q;
   logic irq_d, irq_q;
   // event and latch state
   logic [2:0] ev;
   logic kbd_prev_q, mouse_prev_q, ser_prev_q;
   logic klat_d, klat_q, mlat_d, mlat_q;
   // pin synchronisers: kbd clk, kbd data, mouse clk, mouse data
   logic [3:0] pin_s1_q, pin_s2_q;
   // registered outputs
   logic uart_o_d, uart_o_q, midi_o_d, midi_o_q;
   logic kirq_d, kirq_q, mirq_d, mirq_q;
   logic krst_d, krst_q, a20_d, a20_q;
   logic [3:0] core_pin_d, core_pin_q;
   logic [1:0] wake_q;
   cfg_pkg::reg_e rsel;
   logic rd_req;

   // address phase capture and register write next values
   always_comb begin
      wr_pend_d = HSEL & HTRANS[1] & HWRITE & HREADY;
      wsel_d = regsel_f(HADDR);
      rsel = regsel_f(HADDR);
      rd_req = HSEL & HTRANS[1] & ~HWRITE & HREADY;
      ser_d = ser_q;
      mhi_d = mhi_q;
      mlo_d = mlo_q;
      kbd_d = kbd_q;
      mask_d = mask_q;
      st_d = st_q;
      if (wr_pend_q) begin
         case (wsel_q)
            cfg_pkg::REG_SERIAL: begin
               ser_d = HWDATA[7:0] & cfg_pkg::SER_WR_MASK;
            end
            cfg_pkg::REG_MIDI_HIGH: begin
               mhi_d = HWDATA[7:0] & cfg_pkg::MIDI_HIGH_WR_MASK;
            end
            cfg_pkg::REG_MIDI_LOW: begin
               mlo_d = HWDATA[7:0] & cfg_pkg::MIDI_LOW_WR_MASK;
            end
            cfg_pkg::REG_KBD: begin
               kbd_d = HWDATA[7:0] & cfg_pkg::KBD_WR_MASK;
            end
            cfg_pkg::REG_IRQ_MASK: begin
               mask_d = HWDATA[2:0];
            end
            cfg_pkg::REG_IRQ_STATUS: begin
               st_d = st_q & ~HWDATA[2:0];
            end
            default: begin
               ser_d = ser_q;
            end
         endcase
      end
      // new events win over a clear in the same cycle
      st_d = st_d | ev;
      irq_d = |(st_d & mask_d);
   end

   // read data from next values so a write then read sees fresh data
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_req) begin
         case (rsel)
            cfg_pkg::REG_SERIAL: rdata_d[7:0] = ser_d;
            cfg_pkg::REG_MIDI_HIGH: rdata_d[7:0] = mhi_d;
            cfg_pkg::REG_MIDI_LOW: rdata_d[7:0] = mlo_d;
            cfg_pkg::REG_KBD: rdata_d[7:0] = kbd_d;
            cfg_pkg::REG_IRQ_STATUS: rdata_d[2:0] = st_d;
            cfg_pkg::REG_IRQ_MASK: rdata_d[2:0] = mask_d;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // bus and register flip-flops
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         wr_pend_q <= 1'b0;
         wsel_q <= cfg_pkg::REG_NONE;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         ser_q <= cfg_pkg::SER_RESET;
         mhi_q <= cfg_pkg::MIDI_HIGH_RESET;
         mlo_q <= cfg_pkg::MIDI_LOW_RESET;
         kbd_q <= cfg_pkg::KBD_RESET;
         st_q <= cfg_pkg::IRQ_RESET;
         mask_q <= cfg_pkg::IRQ_RESET;
         irq_q <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wsel_q <= wsel_d;
         rdata_q <= rdata_d;
         ready_q <= 1'b1;
         ser_q <= ser_d;
         mhi_q <= mhi_d;
         mlo_q <= mlo_d;
         kbd_q <= kbd_d;
         st_q <= st_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   // events, latches and output next values
   always_comb begin
      ev = 3'h0;
      ev[cfg_pkg::IRQ_KBD_BIT] = KBD_CORE_IRQ & ~kbd_prev_q;
      ev[cfg_pkg::IRQ_MOUSE_BIT] = MOUSE_CORE_IRQ & ~mouse_prev_q;
      ev[cfg_pkg::IRQ_SERIAL_BIT] = (UART_IRQ | MIDI_IRQ) & ~ser_prev_q;
      // latch sets on a core rise, core ack clears, set wins
      klat_d = ev[cfg_pkg::IRQ_KBD_BIT] | (klat_q & ~KBD_IRQ_ACK);
      mlat_d = ev[cfg_pkg::IRQ_MOUSE_BIT] | (mlat_q & ~MOUSE_IRQ_ACK);
      if (kbd_q[cfg_pkg::KBD_KIRQ_SEL_BIT]) begin
         kirq_d = klat_q;
      end else begin
         kirq_d = KBD_CORE_IRQ & klat_q;
      end
      if (kbd_q[cfg_pkg::KBD_MIRQ_SEL_BIT]) begin
         mirq_d = mlat_q;
      end else begin
         mirq_d = MOUSE_CORE_IRQ & mlat_q;
      end
      // shared mode drives both lines from either source
      if (ser_q[cfg_pkg::SER_SHARE_BIT]) begin
         uart_o_d = UART_IRQ | MIDI_IRQ;
         midi_o_d = UART_IRQ | MIDI_IRQ;
      end else begin
         uart_o_d = UART_IRQ;
         midi_o_d = MIDI_IRQ;
      end
      // reset line polarity
      if (kbd_q[cfg_pkg::KBD_POL_BIT]) begin
         krst_d = RESET_OUTPUT_LINE;
      end else begin
         krst_d = ~RESET_OUTPUT_LINE;
      end
      a20_d = CORE_ADDR20 |
         (kbd_q[cfg_pkg::KBD_P92_BIT] & PORT92_ADDR20);
      // isolated lines idle high toward the core
      core_pin_d[1:0] = kbd_q[cfg_pkg::KBD_KISO_BIT] ?
         2'b11 : pin_s2_q[1:0];
      core_pin_d[3:2] = kbd_q[cfg_pkg::KBD_MISO_BIT] ?
         2'b11 : pin_s2_q[3:2];
   end

   // pin sync, latch and output flip-flops
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         pin_s1_q <= 4'hf;
         pin_s2_q <= 4'hf;
         kbd_prev_q <= 1'b0;
         mouse_prev_q <= 1'b0;
         ser_prev_q <= 1'b0;
         klat_q <= 1'b0;
         mlat_q <= 1'b0;
         kirq_q <= 1'b0;
         mirq_q <= 1'b0;
         uart_o_q <= 1'b0;
         midi_o_q <= 1'b0;
         krst_q <= 1'b1;
         a20_q <= 1'b0;
         core_pin_q <= 4'hf;
         wake_q <= 2'b11;
      end else begin
         pin_s1_q <= {MOUSE_DATA_LINE, MOUSE_CLK_PIN,
            KEYBOARD_DATA_LINE, KBD_CLK_PIN};
         pin_s2_q <= pin_s1_q;
         kbd_prev_q <= KBD_CORE_IRQ;
         mouse_prev_q <= MOUSE_CORE_IRQ;
         ser_prev_q <= UART_IRQ | MIDI_IRQ;
         klat_q <= klat_d;
         mlat_q <= mlat_d;
         kirq_q <= kirq_d;
         mirq_q <= mirq_d;
         uart_o_q <= uart_o_d;
         midi_o_q <= midi_o_d;
         krst_q <= krst_d;
         a20_q <= a20_d;
         core_pin_q <= core_pin_d;
         wake_q <= {pin_s2_q[3], pin_s2_q[1]};
      end
   end

   // port drive
   assign HREADYOUT = ready_q;
   assign HRESP = 1'b0;
   assign HRDATA = rdata_q;
   assign UART_IRQ_OUT = uart_o_q;
   assign MIDI_IRQ_OUT = midi_o_q;
   assign MIDI_MODE_EN = ser_q[cfg_pkg::SER_MIDI_BIT];
   assign HIGH_SPEED_EN = ser_q[cfg_pkg::SER_SPEED_BIT];
   assign MIDI_BASE_ADDR = {mhi_q[3:0], mlo_q};
   assign KEYBOARD_IRQ = kirq_q;
   assign MOUSE_IRQ = mirq_q;
   assign KEYBOARD_RESET_OUT = krst_q;
   assign ADDR20_GATE = a20_q;
   assign PORT92_EN = kbd_q[cfg_pkg::KBD_P92_BIT];
   assign KBD_CLK_TO_CORE = core_pin_q[0];
   assign KBD_DATA_TO_CORE = core_pin_q[1];
   assign MOUSE_CLK_TO_CORE = core_pin_q[2];
   assign MOUSE_DATA_TO_CORE = core_pin_q[3];
   assign KBD_DATA_WAKE = wake_q[0];
   assign MOUSE_DATA_WAKE = wake_q[1];
   assign IRQ_OUT = irq_q;

   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   chk_midi_enable: assert property (
      wr_pend_q && wsel_q == cfg_pkg::REG_SERIAL |=>
      MIDI_MODE_EN == $past(HWDATA[0]))
      else $error("midi enable not taken from write");
   chk_speed_enable: assert property (
      wr_pend_q && wsel_q == cfg_pkg::REG_SERIAL |=>
      HIGH_SPEED_EN == $past(HWDATA[1]))
      else $error("high speed not taken from write");
   chk_serial_rsvd: assert property (ser_q[6:2] == 5'h00)
      else $error("serial reserved bits not zero");
   chk_own_irq: assert property (
      !ser_q[cfg_pkg::SER_SHARE_BIT] ##1 !$changed(ser_q) |->
      UART_IRQ_OUT == $past(UART_IRQ) && MIDI_IRQ_OUT == $past(MIDI_IRQ))
      else $error("unshared irq does not follow own source");
   chk_share_both: assert property (
      ser_q[cfg_pkg::SER_SHARE_BIT] && (UART_IRQ || MIDI_IRQ) |=>
      UART_IRQ_OUT && MIDI_IRQ_OUT)
      else $error("shared irq did not assert both lines");
   chk_midi_low: assert property (
      rd_req && rsel == cfg_pkg::REG_MIDI_LOW |=>
      HRDATA[0] == 1'b0 && HRDATA[31:8] == 24'h00_0000)
      else $error("midi low bit 0 or upper bits not zero");
   chk_midi_high: assert property (MIDI_BASE_ADDR[0] == 1'b0 &&
      mhi_q[7:4] == 4'h0)
      else $error("midi base reserved bits set");
   chk_reset_pol: assert property (
      ##1 KEYBOARD_RESET_OUT == ($past(kbd_q[7]) ?
      $past(RESET_OUTPUT_LINE) : !$past(RESET_OUTPUT_LINE)))
      else $error("keyboard reset polarity wrong");
   chk_mouse_iso: assert property (
      kbd_q[cfg_pkg::KBD_MISO_BIT] |=>
      MOUSE_CLK_TO_CORE && MOUSE_DATA_TO_CORE)
      else $error("mouse lines not blocked");
   chk_mouse_wake: assert property (
      ##3 MOUSE_DATA_WAKE == $past(MOUSE_DATA_LINE, 3))
      else $error("mouse wake data not passed");
   chk_kbd_iso: assert property (
      kbd_q[cfg_pkg::KBD_KISO_BIT] |=> KBD_CLK_TO_CORE &&
      KBD_DATA_TO_CORE && KBD_DATA_WAKE == $past(pin_s2_q[1]))
      else $error("keyboard isolation wrong");
   chk_mouse_latch: assert property (
      ##1 MOUSE_IRQ == ($past(kbd_q[4]) ? $past(mlat_q) :
      ($past(mlat_q) && $past(MOUSE_CORE_IRQ))))
      else $error("mouse irq select wrong");
   chk_kbd_latch: assert property (
      ##1 KEYBOARD_IRQ == ($past(kbd_q[3]) ? $past(klat_q) :
      ($past(klat_q) && $past(KBD_CORE_IRQ))))
      else $error("keyboard irq select wrong");
   chk_port92_gate: assert property (
      !kbd_q[cfg_pkg::KBD_P92_BIT] && !CORE_ADDR20 |=> !ADDR20_GATE)
      else $error("a20 gated while port disabled");
   chk_kbd_rsvd: assert property (
      rd_req && HADDR[13:10] == cfg_pkg::LDN_KBD &&
      HADDR[9:2] > cfg_pkg::IDX_KBD_SELECT |=> HRDATA == 32'h0000_0000)
      else $error("reserved keyboard index not zero");
   chk_set_wins: assert property (
      ev[0] |=> st_q[0])
      else $error("event lost against clear");
   chk_irq_level: assert property (IRQ_OUT == |(st_q & mask_q))
      else $error("interrupt output mismatch");

   cov_share: cover property (ser_q[7] && MIDI_IRQ ##1 UART_IRQ_OUT);
   cov_mouse_iso: cover property (kbd_q[6] && !pin_s2_q[3]);
   cov_irq: cover property (ev[2] ##[1:3] IRQ_OUT);

endmodule : serial_midi_kbd_config

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // short aliases of the map
   localparam logic [3:0] LI = cfg_pkg::LDN_IRQ;
   localparam logic [3:0] LS = cfg_pkg::LDN_SERIAL;
   localparam logic [3:0] LM = cfg_pkg::LDN_MIDI;
   localparam logic [3:0] LK = cfg_pkg::LDN_KBD;
   localparam logic [7:0] XS = cfg_pkg::IDX_SERIAL_MODE;
   localparam logic [7:0] XK = cfg_pkg::IDX_KBD_SELECT;
   localparam logic [7:0] XH = cfg_pkg::IDX_MIDI_HIGH;
   localparam logic [7:0] XL = cfg_pkg::IDX_MIDI_LOW;

   // stimulus and observed signals
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp;
   logic uart_irq = 1'b0, midi_irq = 1'b0, kcore = 1'b0, mcore = 1'b0;
   logic kack = 1'b0, mack = 1'b0, rst_req = 1'b0;
   logic core_a20 = 1'b0, p92_a20 = 1'b1;
   logic kclk = 1'b1, kline = 1'b1, mclk = 1'b1, mline = 1'b1;
   logic uart_out, midi_out, midi_en, hs_en, kbd_irq, mouse_irq;
   logic kbd_rst, a20, p92_en, irq_out;
   logic kclk_c, kline_c, mclk_c, mline_c, kline_w, mline_w;
   logic [31:0] pins_seen;
   logic [11:0] midi_base;
   int n_fail = 0;
   int cmp_count = 0;

   // core and wake lines packed for one compare
   assign pins_seen = {26'h0, kclk_c, kline_c, mclk_c, mline_c,
      kline_w, mline_w};

   // device under test, bus ready looped back
   serial_midi_kbd_config u_serial_midi_kbd_config (
      .CORE_CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
      .HRDATA(hrdata), .UART_IRQ(uart_irq), .MIDI_IRQ(midi_irq),
      .UART_IRQ_OUT(uart_out), .MIDI_IRQ_OUT(midi_out),
      .MIDI_MODE_EN(midi_en), .HIGH_SPEED_EN(hs_en),
      .MIDI_BASE_ADDR(midi_base), .KBD_CORE_IRQ(kcore),
      .MOUSE_CORE_IRQ(mcore), .KBD_IRQ_ACK(kack), .MOUSE_IRQ_ACK(mack),
      .RESET_OUTPUT_LINE(rst_req), .CORE_ADDR20(core_a20),
      .PORT92_ADDR20(p92_a20), .KEYBOARD_IRQ(kbd_irq),
      .MOUSE_IRQ(mouse_irq), .KEYBOARD_RESET_OUT(kbd_rst),
      .ADDR20_GATE(a20), .PORT92_EN(p92_en), .KBD_CLK_PIN(kclk),
      .KEYBOARD_DATA_LINE(kline), .MOUSE_CLK_PIN(mclk),
      .MOUSE_DATA_LINE(mline), .KBD_CLK_TO_CORE(kclk_c),
      .KBD_DATA_TO_CORE(kline_c), .MOUSE_CLK_TO_CORE(mclk_c),
      .MOUSE_DATA_TO_CORE(mline_c), .KBD_DATA_WAKE(kline_w),
      .MOUSE_DATA_WAKE(mline_w), .IRQ_OUT(irq_out)
   );

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // one comparison, counted
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one single-word transfer; flops still hold pre-edge values here
   task bus(input logic w, input logic [3:0] l, input logic [7:0] i,
            input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {18'h0, l, i, 2'h0};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask : bus

   task wr(input logic [3:0] l, input logic [7:0] i, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, l, i, {24'h0, d}, x);
   endtask : wr

   task rd(input string n, input logic [3:0] l, input logic [7:0] i,
           input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, l, i, 32'h0000_0000, x);
      chk(n, e, x);
   endtask : rd

   task settle(input int n);
      repeat (n) @(posedge clk);
   endtask : settle

   // values straight after reset
   task t_reset;
      rd("ser_mode", LS, XS, 32'h0000_0000);
      rd("midi_hi", LM, XH, 32'h0000_0000);
      rd("midi_lo", LM, XL, 32'h0000_0030);
      rd("kbd_sel", LK, XK, 32'h0000_0000);
      chk("base", 32'h0000_0030, {20'h0, midi_base});
      chk("mode_en", 32'h0, {30'h0, midi_en, hs_en});
      chk("kbd_rst", 32'h1, {31'h0, kbd_rst});
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : t_reset

   // mode bits and reserved field
   task t_serial;
      wr(LS, XS, 8'h01);
      settle(3);
      chk("midi_en", 32'h2, {30'h0, midi_en, hs_en});
      wr(LS, XS, 8'h02);
      settle(3);
      chk("hs_en", 32'h1, {30'h0, midi_en, hs_en});
      wr(LS, XS, 8'hff);
      rd("ser_resv", LS, XS, 32'h0000_0083);
      wr(LS, XS, 8'h00);
   endtask : t_serial

   // separate then shared unit interrupts
   task t_share;
      @(posedge clk);
      uart_irq <= 1'b1;
      settle(3);
      chk("separate", 32'h2, {30'h0, uart_out, midi_out});
      uart_irq <= 1'b0;
      wr(LS, XS, 8'h80);
      @(posedge clk);
      midi_irq <= 1'b1;
      settle(3);
      chk("shared", 32'h3, {30'h0, uart_out, midi_out});
      midi_irq <= 1'b0;
      settle(3);
      chk("shared_off", 32'h0, {30'h0, uart_out, midi_out});
      wr(LS, XS, 8'h00);
   endtask : t_share

   // base address fields
   task t_midi;
      wr(LM, XH, 8'hff);
      wr(LM, XL, 8'hff);
      rd("hi_mask", LM, XH, 32'h0000_000f);
      rd("lo_mask", LM, XL, 32'h0000_00fe);
      chk("base_ff", 32'h0000_0ffe, {20'h0, midi_base});
      wr(LM, XH, 8'h05);
      wr(LM, XL, 8'ha4);
      settle(2);
      chk("base_5a4", 32'h0000_05a4, {20'h0, midi_base});
   endtask : t_midi

   // reset polarity and fast a20 port
   task t_kbd;
      wr(LK, XK, 8'hff);
      rd("kbd_resv", LK, XK, 32'h0000_00fc);
      settle(3);
      chk("p92_en", 32'h1, {31'h0, p92_en});
      chk("a20_on", 32'h1, {31'h0, a20});
      chk("rst_hi_idle", 32'h0, {31'h0, kbd_rst});
      rst_req <= 1'b1;
      settle(3);
      chk("rst_hi_act", 32'h1, {31'h0, kbd_rst});
      wr(LK, XK, 8'h00);
      settle(3);
      chk("rst_lo_act", 32'h0, {31'h0, kbd_rst});
      chk("a20_off", 32'h0, {30'h0, a20, p92_en});
      rst_req <= 1'b0;
   endtask : t_kbd

   // isolation of core lines, wakeup untouched
   task t_iso;
      @(posedge clk);
      {kclk, kline, mclk, mline} <= 4'h0;
      settle(5);
      chk("pass", 32'h0, pins_seen);
      wr(LK, XK, 8'h40);
      settle(5);
      chk("m_iso", 32'h0c, pins_seen);
      wr(LK, XK, 8'h20);
      settle(5);
      chk("k_iso", 32'h30, pins_seen);
      wr(LK, XK, 8'h00);
      {kclk, kline, mclk, mline} <= 4'hf;
   endtask : t_iso

   // latched versus anded core interrupts
   task t_latch;
      wr(LK, XK, 8'h18);
      {kcore, mcore} <= 2'h3;
      settle(3);
      chk("lat_on", 32'h3, {30'h0, kbd_irq, mouse_irq});
      {kcore, mcore} <= 2'h0;
      settle(3);
      chk("lat_hold", 32'h3, {30'h0, kbd_irq, mouse_irq});
      {kack, mack} <= 2'h3;
      @(posedge clk);
      {kack, mack} <= 2'h0;
      settle(3);
      chk("lat_ack", 32'h0, {30'h0, kbd_irq, mouse_irq});
      wr(LK, XK, 8'h00);
      {kcore, mcore} <= 2'h3;
      settle(3);
      chk("and_on", 32'h3, {30'h0, kbd_irq, mouse_irq});
      {kcore, mcore} <= 2'h0;
      settle(3);
      chk("and_off", 32'h0, {30'h0, kbd_irq, mouse_irq});
      {kack, mack} <= 2'h3;
      @(posedge clk);
      {kack, mack} <= 2'h0;
   endtask : t_latch

   // sticky status, mask and clear by writing one
   task t_irq;
      wr(LI, cfg_pkg::IDX_IRQ_STATUS, 8'h07);
      rd("st_clr", LI, cfg_pkg::IDX_IRQ_STATUS, 32'h0);
      uart_irq <= 1'b1;
      @(posedge clk);
      uart_irq <= 1'b0;
      settle(3);
      rd("st_set", LI, cfg_pkg::IDX_IRQ_STATUS, 32'h4);
      chk("masked", 32'h0, {31'h0, irq_out});
      wr(LI, cfg_pkg::IDX_IRQ_MASK, 8'h04);
      settle(2);
      chk("unmasked", 32'h1, {31'h0, irq_out});
      wr(LI, cfg_pkg::IDX_IRQ_MASK, 8'h01);
      settle(2);
      chk("other_mask", 32'h0, {31'h0, irq_out});
      wr(LI, cfg_pkg::IDX_IRQ_MASK, 8'h04);
      wr(LI, cfg_pkg::IDX_IRQ_STATUS, 8'h04);
      rd("st_w1c", LI, cfg_pkg::IDX_IRQ_STATUS, 32'h0);
      settle(2);
      chk("cleared", 32'h0, {31'h0, irq_out});
   endtask : t_irq

   // reserved keyboard indices and an unmapped device
   task t_resv;
      for (int i = 8'hf1; i <= 8'hff; i++) begin
         wr(LK, i[7:0], 8'hff);
         rd("kbd_f1_ff", LK, i[7:0], 32'h0000_0000);
      end
      wr(4'h9, 8'h00, 8'hff);
      rd("unmapped", 4'h9, 8'h00, 32'h0000_0000);
   endtask : t_resv

   // verdict and end of run
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   // main sequence
   initial begin
      settle(10);
      rst <= 1'b0;
      settle(2);
      t_reset();
      t_serial();
      t_share();
      t_midi();
      t_kbd();
      t_iso();
      t_latch();
      t_irq();
      t_resv();
      final_report();
   end

   // hang guard, far beyond the few hundred bus cycles used
   initial begin
      settle(20000);
      n_fail++;
      final_report();
   end
endmodule : testbench

`default_nettype wire
